// *** core/bcd_shift_bit_op_timing.v ***
// Execution timing sequencer for decimal, single-operand, shift/rotate
// and bit instructions: picks a timing case, adds the addressing time,
// and places read, prefetch and write requests inside the total.
// Assumes the addressing unit supplies its times with the start pulse.
`timescale 1ns/1ps
`default_nettype none
`include "exec_timing_defines.vh"

// Notes on behaviour
// - Total clocks include read, prefetch, write cycles
// - Decimal and extend group adds no address time
// - Shift time independent of shift count
// - Clear, set-on-condition, test-and-set memory add calc time
// - Other memory single, shift, bit forms add fetch time
// - Immediate-number memory bit forms add immediate time
// - Decimal add registers: 4, 4, 5 with prefetch
// - Extend add registers: 2, 2, 3 with prefetch
// - Memory compare: two reads, 8, 9, 10
// - Sign extend register: 1, 4, 4 with prefetch
// - Decimal negate register: 6 in every case
// - Static logical shift register: 1, 4, 4
// - Dynamic logical shift register: 3, 6, 6
// - Arithmetic right shift register: 3, 6, 6
// - Extend rotate register: 9, 12, 12
// - Rotate left memory: 7 every case, one write
// - Arithmetic left shift memory: 6, 6, 7
// - Extend rotate memory: 5, 5, 6
// - Bit clear registers: 1, 4, 5 with prefetch
module bcd_shift_bit_op_timing #(
    parameter EA_W = 6
) (
    input wire sys_clk,
    input wire rst_n,
    input wire start,
    input wire [`FORM_W-1:0] form,
    input wire exec_overlap,
    input wire cache_hit,
    input wire prefetch_needed,
    input wire [EA_W-1:0] calc_ea_time,
    input wire [EA_W-1:0] fetch_ea_time,
    input wire [EA_W-1:0] fetch_imm_time,
    output wire ready,
    output wire busy,
    output wire done,
    output wire read_req,
    output wire prefetch_req,
    output wire write_req,
    output reg [1:0] case_sel_r,
    output reg [EA_W:0] total_clocks_r,
    output reg [EA_W-1:0] ea_clocks_r,
    output reg [`NUM_W-1:0] read_cycles_r,
    output reg [`NUM_W-1:0] prefetch_cycles_r,
    output reg [`NUM_W-1:0] write_cycles_r,
    output reg bad_form_r
);

    // Counter and table field widths
    localparam CNT_W = EA_W + 1;
    localparam TOT_W = `TOT_W;
    localparam NUM_W = `NUM_W;

    // Sequencer phases
    localparam S_IDLE = 2'h0;
    localparam S_EA = 2'h1;
    localparam S_RUN = 2'h2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`ROW_W-1:0] row_c;
    reg row_bad_c;
    reg [1:0] sel_c;
    reg [`ENT_W-1:0] ent_c;
    reg [EA_W-1:0] ea_add_c;
    reg [TOT_W-1:0] listed_r;
    reg [TOT_W-1:0] run_idx_r;
    reg [TOT_W-1:0] run_idx_nxt;
    reg zero_done_r;
    reg cnt_load;
    reg [CNT_W-1:0] cnt_val;
    wire cnt_last;
    wire accept;
    wire [TOT_W-1:0] listed_c;
    wire [TOT_W-1:0] rd_span;
    wire [TOT_W-1:0] pf_end;
    wire [TOT_W-1:0] wr_start;

    // Timing table, one row per form; no shift count enters the lookup
    always @* begin
        row_bad_c = 1'b0;
        case (form)
            `F_BADD_DD, `F_BSUB_DD:
                row_c = {`EA_NO, 5'h04, 6'h00, 5'h04, 6'h00, 5'h05, 6'h04};
            `F_BADD_MM, `F_BSUB_MM:
                row_c = {`EA_NO, 5'h0e, 6'h21, 5'h10, 6'h21, 5'h11, 6'h25};
            `F_ADDEXT_DD, `F_SUBEXT_DD:
                row_c = {`EA_NO, 5'h02, 6'h00, 5'h02, 6'h00, 5'h03, 6'h04};
            `F_ADDEXT_MM, `F_SUBEXT_MM:
                row_c = {`EA_NO, 5'h0a, 6'h21, 5'h0c, 6'h21, 5'h0d, 6'h25};
            `F_CMPMEM:
                row_c = {`EA_NO, 5'h08, 6'h20, 5'h09, 6'h20, 5'h0a, 6'h24};
            `F_BCDA_DD:
                row_c = {`EA_NO, 5'h03, 6'h00, 5'h06, 6'h00, 5'h07, 6'h04};
            `F_BCDUNPACK_DD:
                row_c = {`EA_NO, 5'h05, 6'h00, 5'h08, 6'h00, 5'h09, 6'h04};
            `F_BCDA_MM, `F_BCDUNPACK_MM:
                row_c = {`EA_NO, 5'h0b, 6'h11, 5'h0d, 6'h11, 5'h0d, 6'h15};
            `F_CLEAR_D, `F_NEGATE_D, `F_NEGEXT_D, `F_COMPL_D:
                row_c = {`EA_NO, 5'h00, 6'h00, 5'h02, 6'h00, 5'h03, 6'h04};
            `F_CLEAR_M:
                row_c = {`EA_CALC, 5'h03, 6'h01, 5'h04, 6'h01, 5'h06, 6'h05};
            `F_NEGATE_M, `F_NEGEXT_M, `F_COMPL_M:
                row_c = {`EA_FETCH, 5'h03, 6'h01, 5'h04, 6'h01, 5'h06, 6'h05};
            `F_SIGNEXT_D, `F_SETCC_D, `F_TESTSET_D:
                row_c = {`EA_NO, 5'h01, 6'h00, 5'h04, 6'h00, 5'h04, 6'h04};
            `F_BCDNEG_D:
                row_c = {`EA_NO, 5'h06, 6'h00, 5'h06, 6'h00, 5'h06, 6'h04};
            `F_SETCC_M:
                row_c = {`EA_CALC, 5'h06, 6'h01, 5'h06, 6'h01, 5'h06, 6'h05};
            `F_TESTSET_M:
                row_c = {`EA_CALC, 5'h0c, 6'h11, 5'h0c, 6'h11, 5'h0d, 6'h15};
            `F_TEST_EA:
                row_c = {`EA_FETCH, 5'h00, 6'h00, 5'h02, 6'h00, 5'h03, 6'h04};
            `F_LSHL_ST, `F_LSHR_ST:
                row_c = {`EA_NO, 5'h01, 6'h00, 5'h04, 6'h00, 5'h04, 6'h04};
            `F_LSHL_DY, `F_LSHR_DY, `F_ASHR_D:
                row_c = {`EA_NO, 5'h03, 6'h00, 5'h06, 6'h00, 5'h06, 6'h04};
            `F_LSHL_M, `F_LSHR_M, `F_ASHR_M, `F_RX_M:
                row_c = {`EA_FETCH, 5'h05, 6'h01, 5'h05, 6'h01, 5'h06, 6'h05};
            `F_ASHL_D, `F_ROTL_D, `F_ROTR_D:
                row_c = {`EA_NO, 5'h05, 6'h00, 5'h08, 6'h00, 5'h08, 6'h04};
            `F_ASHL_M:
                row_c = {`EA_FETCH, 5'h06, 6'h01, 5'h06, 6'h01, 5'h07, 6'h05};
            `F_ROTL_M, `F_ROTR_M:
                row_c = {`EA_FETCH, 5'h07, 6'h01, 5'h07, 6'h01, 5'h07, 6'h05};
            `F_RXL_D, `F_RXR_D:
                row_c = {`EA_NO, 5'h09, 6'h00, 5'h0c, 6'h00, 5'h0c, 6'h04};
            `F_BITTST_ID, `F_BITTST_DD, `F_BITCHG_ID, `F_BITCHG_DD,
            `F_BITCLR_ID, `F_BITCLR_DD, `F_BITSET_ID, `F_BITSET_DD:
                row_c = {`EA_NO, 5'h01, 6'h00, 5'h04, 6'h00, 5'h05, 6'h04};
            `F_BITTST_IM:
                row_c = {`EA_IMM, 5'h04, 6'h00, 5'h04, 6'h00, 5'h05, 6'h04};
            `F_BITTST_DM:
                row_c = {`EA_FETCH, 5'h04, 6'h00, 5'h04, 6'h00, 5'h05, 6'h04};
            `F_BITCHG_IM, `F_BITCLR_IM, `F_BITSET_IM:
                row_c = {`EA_IMM, 5'h04, 6'h01, 5'h04, 6'h01, 5'h05, 6'h05};
            `F_BITCHG_DM, `F_BITCLR_DM, `F_BITSET_DM:
                row_c = {`EA_FETCH, 5'h04, 6'h01, 5'h04, 6'h01, 5'h05, 6'h05};
            default: begin
                row_c = {`ROW_W{1'b0}};
                row_bad_c = 1'b1;
            end
        endcase
    end

    // Case choice: a needed prefetch forces worst, overlap gives best
    always @* begin
        if (prefetch_needed) begin
            sel_c = `CASE_WORST;
        end else if (exec_overlap) begin
            sel_c = `CASE_BEST;
        end else begin
            sel_c = `CASE_CACHE;
        end
    end

    // Entry of the chosen case
    always @* begin
        case (sel_c)
            `CASE_BEST: ent_c = row_c[`ROW_BEST];
            `CASE_CACHE: ent_c = row_c[`ROW_CACHE];
            default: ent_c = row_c[`ROW_WORST];
        endcase
    end

    // Addressing time to add ahead of the listed clocks
    always @* begin
        case (row_c[`ROW_EA])
            `EA_CALC: ea_add_c = calc_ea_time;
            `EA_FETCH: ea_add_c = fetch_ea_time;
            `EA_IMM: ea_add_c = fetch_imm_time;
            default: ea_add_c = {EA_W{1'b0}};
        endcase
    end

    assign listed_c = ent_c[`ENT_TOT];
    assign accept = start && (state_r == S_IDLE);

    // Phase sequencing: addressing phase first, then the listed clocks
    always @* begin
        state_nxt = state_r;
        cnt_load = 1'b0;
        cnt_val = {CNT_W{1'b0}};
        case (state_r)
            S_IDLE: begin
                if (accept && (ea_add_c != {EA_W{1'b0}})) begin
                    state_nxt = S_EA;
                    cnt_load = 1'b1;
                    cnt_val = {1'b0, ea_add_c};
                end else if (accept && (listed_c != {TOT_W{1'b0}})) begin
                    state_nxt = S_RUN;
                    cnt_load = 1'b1;
                    cnt_val = {{(CNT_W-TOT_W){1'b0}}, listed_c};
                end
            end
            S_EA: begin
                if (cnt_last && (listed_r != {TOT_W{1'b0}})) begin
                    state_nxt = S_RUN;
                    cnt_load = 1'b1;
                    cnt_val = {{(CNT_W-TOT_W){1'b0}}, listed_r};
                end else if (cnt_last) begin
                    state_nxt = S_IDLE;
                end
            end
            S_RUN: begin
                if (cnt_last) begin
                    state_nxt = S_IDLE;
                end
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    // Run index counts the cycles of the run phase
    always @* begin
        run_idx_nxt = {TOT_W{1'b0}};
        if ((state_r == S_RUN) && !cnt_last) begin
            run_idx_nxt = run_idx_r + {{(TOT_W-1){1'b0}}, 1'b1};
        end
    end

    // Shared counter for the addressing and run phases
    cycle_counter #(
        .W(CNT_W)
    ) u_phase_cnt (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(cnt_load),
        .load_val(cnt_val),
        .count_en(state_r != S_IDLE),
        .count_r(),
        .last(cnt_last)
    );

    // Latched timing of the accepted operation
    always @(posedge sys_clk) begin
        // Reset clears the phase and latched outputs
        if (!rst_n) begin
            state_r <= S_IDLE;
            run_idx_r <= {TOT_W{1'b0}};
            zero_done_r <= 1'b0;
            listed_r <= {TOT_W{1'b0}};
            case_sel_r <= `CASE_BEST;
            total_clocks_r <= {CNT_W{1'b0}};
            ea_clocks_r <= {EA_W{1'b0}};
            read_cycles_r <= {NUM_W{1'b0}};
            prefetch_cycles_r <= {NUM_W{1'b0}};
            write_cycles_r <= {NUM_W{1'b0}};
            bad_form_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            run_idx_r <= run_idx_nxt;
            zero_done_r <= accept && (ea_add_c == {EA_W{1'b0}}) &&
                (listed_c == {TOT_W{1'b0}});
            if (accept) begin
                listed_r <= listed_c;
                case_sel_r <= sel_c;
                total_clocks_r <= {{(CNT_W-TOT_W){1'b0}}, listed_c} +
                    {1'b0, ea_add_c};
                ea_clocks_r <= ea_add_c;
                read_cycles_r <= ent_c[`ENT_RD];
                prefetch_cycles_r <= ent_c[`ENT_PF];
                write_cycles_r <= ent_c[`ENT_WR];
                bad_form_r <= row_bad_c;
            end
        end
    end

    // Bus cycles sit inside the listed clocks: reads first, then the
    // prefetch, writes in the closing cycles
    assign rd_span = {{(TOT_W-NUM_W){1'b0}}, read_cycles_r};
    assign pf_end = rd_span + {{(TOT_W-NUM_W){1'b0}}, prefetch_cycles_r};
    assign wr_start = listed_r - {{(TOT_W-NUM_W){1'b0}}, write_cycles_r};

    assign read_req = (state_r == S_RUN) && (run_idx_r < rd_span);
    assign prefetch_req = (state_r == S_RUN) && (run_idx_r >= rd_span) &&
        (run_idx_r < pf_end);
    assign write_req = (state_r == S_RUN) &&
        (write_cycles_r != {NUM_W{1'b0}}) &&
        (run_idx_r >= wr_start);

    // Handshake outputs; done marks the final busy cycle, or the idle cycle after a zero-clock start
    assign ready = (state_r == S_IDLE);
    assign busy = (state_r != S_IDLE);
    assign done = zero_done_r ||
        (cnt_last && (state_r == S_RUN)) ||
        (cnt_last && (state_r == S_EA) &&
        (listed_r == {TOT_W{1'b0}}));

endmodule // bcd_shift_bit_op_timing

`default_nettype wire

// *** core/cycle_counter.v ***
// Loadable down counter for one timing phase.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module cycle_counter #(
    parameter W = 7
) (
    input wire sys_clk,
    input wire rst_n,
    input wire load,
    input wire [W-1:0] load_val,
    input wire count_en,
    output reg [W-1:0] count_r,
    output wire last
);

    reg [W-1:0] count_nxt;

    // Count of one means the current cycle is the phase's final one
    assign last = (count_r == {{(W-1){1'b0}}, 1'b1});

    always @* begin
        count_nxt = count_r;
        if (load) begin
            count_nxt = load_val;
        end else if (count_en && (count_r != {W{1'b0}})) begin
            count_nxt = count_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            count_r <= {W{1'b0}};
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule // cycle_counter

`default_nettype wire

// *** core/exec_timing_defines.vh ***
// Constants for the execution timing sequencer: form codes, case codes,
// table row layout and effective-address adder kinds.
// Assumes inclusion by the timing sequencer, bench and checker; definitions only.
`ifndef EXEC_TIMING_DEFINES_VH
`define EXEC_TIMING_DEFINES_VH

// Timing case selection
`define CASE_BEST 2'h0
`define CASE_CACHE 2'h1
`define CASE_WORST 2'h2

// Effective-address time adder kinds
`define EA_NO 2'h0
`define EA_CALC 2'h1
`define EA_FETCH 2'h2
`define EA_IMM 2'h3

// Row layout: adder kind, then best, cache and worst entries
`define ROW_W 35
`define ROW_EA 34:33
`define ROW_BEST 32:22
`define ROW_CACHE 21:11
`define ROW_WORST 10:0
// Entry layout: total clocks, reads, prefetches, writes
`define ENT_W 11
`define ENT_TOT 10:6
`define ENT_RD 5:4
`define ENT_PF 3:2
`define ENT_WR 1:0
`define TOT_W 5
`define NUM_W 2

// Form codes
`define FORM_W 6
`define F_BADD_DD 6'h00
`define F_BADD_MM 6'h01
`define F_BSUB_DD 6'h02
`define F_BSUB_MM 6'h03
`define F_ADDEXT_DD 6'h04
`define F_ADDEXT_MM 6'h05
`define F_SUBEXT_DD 6'h06
`define F_SUBEXT_MM 6'h07
`define F_CMPMEM 6'h08
`define F_BCDA_DD 6'h09
`define F_BCDA_MM 6'h0a
`define F_BCDUNPACK_DD 6'h0b
`define F_BCDUNPACK_MM 6'h0c
`define F_CLEAR_D 6'h0d
`define F_CLEAR_M 6'h0e
`define F_NEGATE_D 6'h0f
`define F_NEGATE_M 6'h10
`define F_NEGEXT_D 6'h11
`define F_NEGEXT_M 6'h12
`define F_COMPL_D 6'h13
`define F_COMPL_M 6'h14
`define F_SIGNEXT_D 6'h15
`define F_BCDNEG_D 6'h16
`define F_SETCC_D 6'h17
`define F_SETCC_M 6'h18
`define F_TESTSET_D 6'h19
`define F_TESTSET_M 6'h1a
`define F_TEST_EA 6'h1b
`define F_LSHL_ST 6'h1c
`define F_LSHR_ST 6'h1d
`define F_LSHL_DY 6'h1e
`define F_LSHR_DY 6'h1f
`define F_LSHL_M 6'h20
`define F_LSHR_M 6'h21
`define F_ASHL_D 6'h22
`define F_ASHR_D 6'h23
`define F_ASHL_M 6'h24
`define F_ASHR_M 6'h25
`define F_ROTL_D 6'h26
`define F_ROTR_D 6'h27
`define F_ROTL_M 6'h28
`define F_ROTR_M 6'h29
`define F_RXL_D 6'h2a
`define F_RXR_D 6'h2b
`define F_RX_M 6'h2c
`define F_BITTST_ID 6'h2d
`define F_BITTST_DD 6'h2e
`define F_BITTST_IM 6'h2f
`define F_BITTST_DM 6'h30
`define F_BITCHG_ID 6'h31
`define F_BITCHG_DD 6'h32
`define F_BITCHG_IM 6'h33
`define F_BITCHG_DM 6'h34
`define F_BITCLR_ID 6'h35
`define F_BITCLR_DD 6'h36
`define F_BITCLR_IM 6'h37
`define F_BITCLR_DM 6'h38
`define F_BITSET_ID 6'h39
`define F_BITSET_DD 6'h3a
`define F_BITSET_IM 6'h3b
`define F_BITSET_DM 6'h3c

`endif

// *** dv/bus_model.sv ***
// Bus side model: counts the read, prefetch and write cycles of one op.
// Assumes strobes with no acknowledge, one bus cycle per strobe.
`timescale 1ns/1ps
`default_nettype none
module bus_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic ready,
    input wire logic read_req,
    input wire logic prefetch_req,
    input wire logic write_req,
    output logic [3:0] n_rd,
    output logic [3:0] n_pf,
    output logic [3:0] n_wr
);
    // Counts restart at each accepted operation
    always @(posedge sys_clk) begin
        if (!rst_n || (start && ready)) begin
            n_rd <= 4'h0;
            n_pf <= 4'h0;
            n_wr <= 4'h0;
        end else begin
            n_rd <= n_rd + {3'h0, read_req};
            n_pf <= n_pf + {3'h0, prefetch_req};
            n_wr <= n_wr + {3'h0, write_req};
        end
    end
endmodule // bus_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the execution timing sequencer.
// Assumes the checker is bound in and the bus model counts strobes.
`timescale 1ns/1ps
`default_nettype none
`include "exec_timing_defines.vh"
module testbench;
    logic sys_clk, rst_n, start, exec_overlap, cache_hit, prefetch_needed;
    logic [`FORM_W-1:0] form;
    logic [5:0] calc_ea_time, fetch_ea_time, fetch_imm_time;
    wire ready, busy, done, read_req, prefetch_req, write_req, bad_form_r;
    wire [1:0] case_sel_r, read_cycles_r, prefetch_cycles_r, write_cycles_r;
    wire [6:0] total_clocks_r;
    wire [5:0] ea_clocks_r;
    wire [3:0] n_rd, n_pf, n_wr;
    logic [5:0] fl [0:18];
    int seed, n_mismatch, num_checks, i, j;

    bcd_shift_bit_op_timing #(.EA_W(6)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .start(start), .form(form),
        .exec_overlap(exec_overlap), .cache_hit(cache_hit),
        .prefetch_needed(prefetch_needed), .calc_ea_time(calc_ea_time),
        .fetch_ea_time(fetch_ea_time), .fetch_imm_time(fetch_imm_time),
        .ready(ready), .busy(busy), .done(done), .read_req(read_req),
        .prefetch_req(prefetch_req), .write_req(write_req),
        .case_sel_r(case_sel_r), .total_clocks_r(total_clocks_r),
        .ea_clocks_r(ea_clocks_r), .read_cycles_r(read_cycles_r),
        .prefetch_cycles_r(prefetch_cycles_r),
        .write_cycles_r(write_cycles_r), .bad_form_r(bad_form_r));
    bus_model bm (.sys_clk(sys_clk), .rst_n(rst_n), .start(start),
        .ready(ready), .read_req(read_req), .prefetch_req(prefetch_req),
        .write_req(write_req), .n_rd(n_rd), .n_pf(n_pf), .n_wr(n_wr));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Adder kind, then best, cache, worst as total/reads/prefetch/writes
    function automatic logic [61:0] exp_row(input logic [5:0] f);
        case (f)
        `F_BADD_DD:
            exp_row = {`EA_NO, 20'h04000, 20'h04000, 20'h05010};
        `F_BADD_MM:
            exp_row = {`EA_NO, 20'h0e201, 20'h10201, 20'h11211};
        `F_ADDEXT_DD:
            exp_row = {`EA_NO, 20'h02000, 20'h02000, 20'h03010};
        `F_CMPMEM:
            exp_row = {`EA_NO, 20'h08200, 20'h09200, 20'h0a210};
        `F_SIGNEXT_D:
            exp_row = {`EA_NO, 20'h01000, 20'h04000, 20'h04010};
        `F_BCDNEG_D:
            exp_row = {`EA_NO, 20'h06000, 20'h06000, 20'h06010};
        `F_LSHL_ST, `F_LSHR_ST:
            exp_row = {`EA_NO, 20'h01000, 20'h04000, 20'h04010};
        `F_LSHL_DY, `F_LSHR_DY, `F_ASHR_D:
            exp_row = {`EA_NO, 20'h03000, 20'h06000, 20'h06010};
        `F_RXL_D, `F_RXR_D:
            exp_row = {`EA_NO, 20'h09000, 20'h0c000, 20'h0c010};
        `F_ROTL_M:
            exp_row = {`EA_FETCH, 20'h07001, 20'h07001, 20'h07011};
        `F_ASHL_M:
            exp_row = {`EA_FETCH, 20'h06001, 20'h06001, 20'h07011};
        `F_RX_M:
            exp_row = {`EA_FETCH, 20'h05001, 20'h05001, 20'h06011};
        `F_NEGATE_M:
            exp_row = {`EA_FETCH, 20'h03001, 20'h04001, 20'h06011};
        `F_BITCLR_DD:
            exp_row = {`EA_NO, 20'h01000, 20'h04000, 20'h05010};
        `F_CLEAR_M:
            exp_row = {`EA_CALC, 20'h03001, 20'h04001, 20'h06011};
        `F_TESTSET_M:
            exp_row = {`EA_CALC, 20'h0c101, 20'h0c101, 20'h0d111};
        `F_BITCLR_IM:
            exp_row = {`EA_IMM, 20'h04001, 20'h04001, 20'h05011};
        default: exp_row = 62'h0;
        endcase
    endfunction

    task automatic check(input bit ok, input string what);
        num_checks++;
        if (!ok) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask

    // One operation, with a refused start in its second busy cycle when it is busy for two or more cycles
    task automatic run_op(input logic [5:0] f, input int cs);
        logic [61:0] row;
        logic [19:0] ent;
        logic [5:0] ta, tb, tc;
        int e, n, l, r, p, w, k, c, last;
        begin
            row = exp_row(f);
            ent = row[59 - 20 * cs -: 20];
            ta = 6'($random(seed));
            tb = 6'($random(seed));
            tc = 6'($random(seed));
            case (row[61:60])
            `EA_CALC: e = ta;
            `EA_FETCH: e = tb;
            `EA_IMM: e = tc;
            default: e = 0;
            endcase
            l = ent[19:12];
            r = ent[11:8];
            p = ent[7:4];
            w = ent[3:0];
            n = e + l;
            last = (n > 0) ? n : 1;
            @(posedge sys_clk);
            start <= 1'b1;
            form <= f;
            calc_ea_time <= ta;
            fetch_ea_time <= tb;
            fetch_imm_time <= tc;
            prefetch_needed <= (cs == 2);
            exec_overlap <= (cs == 0) || (cs == 2 && ta[0]);
            cache_hit <= tb[0];
            @(posedge sys_clk);
            start <= 1'b0;
            #1;
            check({case_sel_r, total_clocks_r, ea_clocks_r,
                read_cycles_r, prefetch_cycles_r, write_cycles_r, bad_form_r}
                === {cs[1:0], 7'(n), 6'(e), ent[9:8], ent[5:4], ent[1:0],
                f == 6'h3f}, "latched timing");
            for (c = 1; c <= last; c++) begin
                if (c > 1) begin
                    @(posedge sys_clk);
                    start <= (c == 2);
                    form <= ~f;
                    #1;
                end
                k = c - 1 - e;
                check({busy, done, read_req, prefetch_req,
                    write_req} === {c <= n, c == last, k >= 0 && k < r,
                    k >= r && k < r + p, k >= l - w && k >= 0 && c <= n},
                    "cycle outputs");
            end
            @(posedge sys_clk);
            start <= 1'b0;
            #1;
            check(ready === 1'b1 && busy === 1'b0 &&
                {n_rd, n_pf, n_wr} === {ent[11:8], ent[7:4], ent[3:0]},
                "bus cycle counts");
        end
    endtask

    task conclude;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    initial begin
        #750000;
        n_mismatch++;
        $display("MISMATCH %0t watchdog expired", $time);
        conclude;
    end

    initial begin
        seed = 15478;
        {rst_n, start, exec_overlap, cache_hit, prefetch_needed} = 5'h0;
        {form, calc_ea_time, fetch_ea_time, fetch_imm_time} = 24'h0;
        fl = '{`F_BADD_DD, `F_BADD_MM, `F_ADDEXT_DD, `F_CMPMEM, `F_SIGNEXT_D,
            `F_BCDNEG_D, `F_LSHL_ST, `F_LSHR_ST, `F_LSHL_DY, `F_LSHR_DY,
            `F_ASHR_D, `F_RXL_D, `F_RXR_D, `F_ROTL_M, `F_ASHL_M, `F_RX_M,
            `F_BITCLR_DD, `F_CLEAR_M, 6'h3f};
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 19; i++)
            for (j = 0; j < 3; j++)
                run_op(fl[i], j);
        run_op(`F_TESTSET_M, 2);
        run_op(`F_BITCLR_IM, 0);
        run_op(`F_NEGATE_M, 1);
        $display("table test done");
        repeat (60) begin
            i = $unsigned($random(seed)) % 19;
            run_op(fl[i], $unsigned($random(seed)) % 3);
        end
        $display("random test done");
        @(posedge sys_clk);
        start <= 1'b1;
        form <= `F_RXL_D;
        @(posedge sys_clk);
        start <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        check(ready === 1'b1 && busy === 1'b0 && done === 1'b0 &&
            total_clocks_r === 7'h00, "reset in mid-run");
        $display("reset test done");
        conclude;
    end
endmodule // testbench
`default_nettype wire

// *** dv/timing_checker_properties.sv ***
// Concurrent checks on the ports of the execution timing sequencer.
// Assumes it is bound onto bcd_shift_bit_op_timing.
`timescale 1ns/1ps
`default_nettype none
`include "exec_timing_defines.vh"
module timing_checker #(
    parameter EA_W = 6
) (
    input wire sys_clk,
    input wire rst_n,
    input wire start,
    input wire [`FORM_W-1:0] form,
    input wire exec_overlap,
    input wire prefetch_needed,
    input wire [EA_W-1:0] calc_ea_time,
    input wire [EA_W-1:0] fetch_ea_time,
    input wire [EA_W-1:0] fetch_imm_time,
    input wire ready,
    input wire busy,
    input wire done,
    input wire read_req,
    input wire prefetch_req,
    input wire write_req,
    input wire [1:0] case_sel_r,
    input wire [EA_W:0] total_clocks_r,
    input wire [EA_W-1:0] ea_clocks_r,
    input wire [`NUM_W-1:0] read_cycles_r,
    input wire [`NUM_W-1:0] write_cycles_r
);
    logic [7:0] busy_cnt_r;
    wire acc;
    assign acc = start && ready;
    // Busy cycles seen so far in this run
    always @(posedge sys_clk) begin
        if (!rst_n || !busy) busy_cnt_r <= 8'h00;
        else busy_cnt_r <= busy_cnt_r + 8'h01;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_req_in_busy: assert property (
        (read_req || prefetch_req || write_req) |-> busy)
        else $error("bus request outside busy");
    a_req_onehot: assert property (
        $onehot0({read_req, prefetch_req, write_req}))
        else $error("two bus requests at once");
    a_done_length: assert property (
        done && busy |-> busy_cnt_r + 8'h01 == total_clocks_r)
        else $error("busy span");
    a_case_worst: assert property (
        acc && prefetch_needed |=> case_sel_r == `CASE_WORST)
        else $error("worst case");
    a_case_best: assert property (
        acc && !prefetch_needed && exec_overlap |=>
        case_sel_r == `CASE_BEST) else $error("best case");
    a_case_cache: assert property (
        acc && !prefetch_needed && !exec_overlap |=>
        case_sel_r == `CASE_CACHE) else $error("cache case");
    a_dec_no_adder: assert property (
        acc && (form == `F_BADD_DD || form == `F_BADD_MM ||
        form == `F_CMPMEM) |=> ea_clocks_r == 0)
        else $error("decimal form took an adder");
    a_calc_adder: assert property (
        acc && (form == `F_CLEAR_M || form == `F_TESTSET_M) |=>
        ea_clocks_r == $past(calc_ea_time)) else $error("calc adder");
    a_fetch_adder: assert property (
        acc && (form == `F_ROTL_M || form == `F_RX_M) |=>
        ea_clocks_r == $past(fetch_ea_time)) else $error("fetch adder");
    a_imm_adder: assert property (
        acc && form == `F_BITCLR_IM |=>
        ea_clocks_r == $past(fetch_imm_time)) else $error("imm adder");
    a_cmp_reads: assert property (
        acc && form == `F_CMPMEM |=>
        read_cycles_r == 2'h2 && write_cycles_r == 2'h0)
        else $error("compare bus counts");
    a_rotl_total: assert property (
        acc && form == `F_ROTL_M |=>
        total_clocks_r == 7'h07 + $past(fetch_ea_time))
        else $error("rotate memory total");
    a_rxl_span: assert property (
        acc && form == `F_RXL_D && exec_overlap && !prefetch_needed |=>
        busy [*8] ##1 (busy && done) ##1 !busy)
        else $error("rotate register span");
endmodule // timing_checker
bind bcd_shift_bit_op_timing timing_checker #(.EA_W(EA_W)) chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .start(start), .form(form),
    .exec_overlap(exec_overlap), .prefetch_needed(prefetch_needed),
    .calc_ea_time(calc_ea_time), .fetch_ea_time(fetch_ea_time),
    .fetch_imm_time(fetch_imm_time), .ready(ready), .busy(busy),
    .done(done), .read_req(read_req), .prefetch_req(prefetch_req),
    .write_req(write_req), .case_sel_r(case_sel_r),
    .total_clocks_r(total_clocks_r), .ea_clocks_r(ea_clocks_r),
    .read_cycles_r(read_cycles_r), .write_cycles_r(write_cycles_r));
`default_nettype wire
